// >>> pio_defines.svh
// constants for the parallel i/o port bank
`ifndef PIO_DEFINES_SVH
`define PIO_DEFINES_SVH

// port widths
`define PIO_P0_W 16
`define PIO_P1_W 16
`define PIO_P2_W 14
`define PIO_P3_W 12
`define PIO_P4_W 8
`define PIO_P5_W 10
// bit offsets inside the flat pin vectors
`define PIO_P0_LO 0
`define PIO_P1_LO 16
`define PIO_P2_LO 32
`define PIO_P3_LO 46
`define PIO_P4_LO 58
`define PIO_P5_LO 66
`define PIO_IO_LINES 66
`define PIO_ALL_LINES 76
// port select codes
`define PIO_PORT0 3'h0
`define PIO_PORT1 3'h1
`define PIO_PORT2 3'h2
`define PIO_PORT3 3'h3
`define PIO_PORT4 3'h4
`define PIO_PORT5 3'h5
// reset values
`define PIO_DATA_RST 16'h0000
`define PIO_DIR_RST 16'h0000
`define PIO_OD_RST 16'h0000
`define PIO_IN_RST 16'h0000
// shared port 1 pins taken by the extension peripherals
`define PIO_PULSE_PINS 16'h000F
`define PIO_ASYNC_PINS 16'h0030
`define PIO_SYNC_PINS 16'h01C0
// enable bit positions of the extension peripheral enables
`define PIO_XEN_PWM 0
`define PIO_XEN_ASC 1
`define PIO_XEN_SSC 2
// state time: cpu clocks per input sample
`define PIO_STATE_CLKS 4'h2

`endif

// >>> pio_pkg.sv
// types for the parallel i/o port bank
package pio_pkg;

    typedef enum logic [2:0] {
        TGT_DATA,
        TGT_DIR,
        TGT_OD,
        TGT_XDATA,
        TGT_XDIR,
        TGT_XOD
    } pio_target_type;

    typedef enum logic [2:0] {
        OP_READ,
        OP_WRITE,
        OP_SET,
        OP_CLEAR,
        OP_TOGGLE
    } pio_op_type;

    typedef struct packed {
        logic           valid;
        pio_target_type target;
        logic [2:0]     port;
        pio_op_type     op;
        logic [15:0]    mask;
        logic [15:0]    data;
    } pio_req_type;

    typedef struct packed {
        logic [15:0] en;
        logic [15:0] out;
        logic [15:0] dir;
        logic [15:0] od;
    } pio_ovr_type;

endpackage

// >>> pio_sync.sv
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps
module pio_sync #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_reg;

    // first stage feeds only the second
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            meta_reg <= '0;
            o_sync   <= '0;
        end else begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule

// >>> pio_port.sv
// one bidirectional port: latches, direction, open drain, pin driver
`timescale 1ns/1ps
`include "pio_defines.svh"
module pio_port #(
    parameter int W     = 8,
    parameter bit OD_EN = 1'b0
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_b,
    input  wire logic         i_st_en,
    input  wire logic [W-1:0] i_pin,
    input  wire logic         i_data_we,
    input  wire logic         i_dir_we,
    input  wire logic         i_od_we,
    input  wire logic [W-1:0] i_wval,
    input  wire logic [W-1:0] i_wmask,
    input  wire logic [W-1:0] i_ovr_en,
    input  wire logic [W-1:0] i_ovr_out,
    input  wire logic [W-1:0] i_ovr_dir,
    input  wire logic [W-1:0] i_ovr_od,
    output logic      [W-1:0] o_rd,
    output logic      [W-1:0] o_pin_out,
    output logic      [W-1:0] o_pin_oe_b
);
    logic [W-1:0] in_reg;
    logic [W-1:0] data_reg;
    logic [W-1:0] dir_reg;
    logic [W-1:0] od_reg;
    logic [W-1:0] eff_out;
    logic [W-1:0] eff_dir;
    logic [W-1:0] eff_od;
    logic [W-1:0] drive;

    // pin sampled every state time whatever the direction
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            in_reg <= W'(`PIO_IN_RST);
        end else if (i_st_en) begin
            in_reg <= i_pin;
        end
    end

    // output latch takes writes in either direction
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            data_reg <= W'(`PIO_DATA_RST);
        end else if (i_data_we) begin
            data_reg <= (data_reg & ~i_wmask) | (i_wval & i_wmask);
        end
    end

    // direction bits, all inputs after reset
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            dir_reg <= W'(`PIO_DIR_RST);
        end else if (i_dir_we) begin
            dir_reg <= (dir_reg & ~i_wmask) | (i_wval & i_wmask);
        end
    end

    // open drain selects, push/pull after reset
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            od_reg <= W'(`PIO_OD_RST);
        end else if (i_od_we && OD_EN) begin
            od_reg <= (od_reg & ~i_wmask) | (i_wval & i_wmask);
        end
    end

    // output lines read the latch, input lines the sampled pin
    assign o_rd = (dir_reg & data_reg) | (~dir_reg & in_reg);

    // override replaces the standard bits entirely on taken lines
    assign eff_out = (i_ovr_en & i_ovr_out) | (~i_ovr_en & data_reg);
    assign eff_dir = (i_ovr_en & i_ovr_dir) | (~i_ovr_en & dir_reg);
    assign eff_od  = (i_ovr_en & i_ovr_od) | (~i_ovr_en & (OD_EN ? od_reg : '0));
    // open drain high releases the pin
    assign drive   = eff_dir & ~(eff_od & eff_out);

    // pin driver registered
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_pin_out  <= '0;
            o_pin_oe_b <= '1;
        end else begin
            o_pin_out  <= eff_out;
            o_pin_oe_b <= ~drive;
        end
    end
endmodule

// >>> pio_bank.sv
// parallel i/o port bank: six port words, 76 lines, access decode
`timescale 1ns/1ps
`include "pio_defines.svh"
// Notes on behaviour
// - lines form two 16-bit, one 14-bit, one 12-bit and one 8-bit bidirectional port plus a 10-bit input port.
// - the bank has 76 lines in all.
// - each line serves software or is taken over by a peripheral or the bus controller.
// - every line is bit addressable and each bidirectional line has its own direction bit.
// - a bidirectional line set as input has its driver off and floats.
// - ports 2, 3 and 4 choose push/pull or open drain per pin.
// - each pin level is sampled into the input latch every state time in either direction.
// - on an input line a write updates the output latch and a read returns the sampled pin.
// - on an input line a read-modify-write takes the pin level and writes the output latch.
// - on an output line a write updates the latch and drives the pin.
// - on an output line a read returns the output latch.
// - on an output line a read-modify-write takes the latch and writes it back.
// - shared pins follow a separate register set while extension peripherals are enabled.
// - with extension peripherals disabled the shared pins follow alternate functions where enabled, else the standard bits.
// - an open drain bit of 0, the reset value, gives push/pull and 1 gives open drain.
// - after reset every bidirectional line is an input.
module pio_bank (
    input  wire logic        I_CLK,
    input  wire logic        I_RST_B,
    input  wire logic        I_REQ_VALID,
    input  wire logic [2:0]  I_REQ_TARGET,
    input  wire logic [2:0]  I_REQ_PORT,
    input  wire logic [2:0]  I_REQ_OP,
    input  wire logic [15:0] I_REQ_MASK,
    input  wire logic [15:0] I_REQ_DATA,
    input  wire logic [2:0]  I_XPER_EN,
    input  wire logic [75:0] I_PIN_IN,
    input  wire logic [65:0] I_ALT_EN,
    input  wire logic [65:0] I_ALT_OUT,
    input  wire logic [65:0] I_ALT_DIR,
    output logic      [65:0] O_PIN_OUT,
    output logic      [65:0] O_PIN_OE_B,
    output logic      [15:0] O_RD_DATA,
    output logic             O_RD_VALID
);
    pio_pkg::pio_req_type req;
    pio_pkg::pio_ovr_type p1_ovr;
    logic [75:0] pin_sync;
    logic [3:0]  st_cnt_reg;
    logic        st_en_reg;
    logic [15:0] rd0;
    logic [15:0] rd1;
    logic [13:0] rd2;
    logic [11:0] rd3;
    logic [7:0]  rd4;
    logic [9:0]  p5_in_reg;
    logic [15:0] xdata_reg;
    logic [15:0] xdir_reg;
    logic [15:0] xod_reg;
    logic [15:0] xmask;
    logic [15:0] src;
    logic [15:0] nval;
    logic        wr;
    logic [5:0]  data_we;
    logic [5:0]  dir_we;
    logic [5:0]  od_we;

    // request gathered into one carrier
    assign req = '{valid:  I_REQ_VALID,
                   target: pio_pkg::pio_target_type'(I_REQ_TARGET),
                   port:   I_REQ_PORT,
                   op:     pio_pkg::pio_op_type'(I_REQ_OP),
                   mask:   I_REQ_MASK,
                   data:   I_REQ_DATA};
    assign wr  = req.valid && (req.op != pio_pkg::OP_READ);

    // all 76 pins resynchronised before any sampling
    pio_sync #(
        .W (`PIO_ALL_LINES)
    ) u_sync (
        .i_clk   (I_CLK),
        .i_rst_b (I_RST_B),
        .i_async (I_PIN_IN),
        .o_sync  (pin_sync)
    );

    // state time divider, one enable pulse per state time
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            st_cnt_reg <= 4'h0;
            st_en_reg  <= 1'b0;
        end else if (st_cnt_reg == `PIO_STATE_CLKS - 4'h1) begin
            st_cnt_reg <= 4'h0;
            st_en_reg  <= 1'b1;
        end else begin
            st_cnt_reg <= st_cnt_reg + 4'h1;
            st_en_reg  <= 1'b0;
        end
    end

    // input-only port: no latch or direction, only the sample
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            p5_in_reg <= 10'(`PIO_IN_RST);
        end else if (st_en_reg) begin
            p5_in_reg <= pin_sync[`PIO_P5_LO +: `PIO_P5_W];
        end
    end

    // read-modify-write source: pin on inputs, latch on outputs
    always_comb begin
        src = 16'h0000;
        unique case (req.target)
            pio_pkg::TGT_XDATA: src = xdata_reg;
            pio_pkg::TGT_XDIR:  src = xdir_reg;
            pio_pkg::TGT_XOD:   src = xod_reg;
            pio_pkg::TGT_DIR,
            pio_pkg::TGT_OD:    src = 16'h0000;
            default: begin
                unique case (req.port)
                    `PIO_PORT0: src = rd0;
                    `PIO_PORT1: src = rd1;
                    `PIO_PORT2: src = {2'h0, rd2};
                    `PIO_PORT3: src = {4'h0, rd3};
                    `PIO_PORT4: src = {8'h0, rd4};
                    `PIO_PORT5: src = {6'h00, p5_in_reg};
                    default:    src = 16'h0000;
                endcase
            end
        endcase
    end

    // new value from source and operand
    always_comb begin
        unique case (req.op)
            pio_pkg::OP_WRITE:  nval = req.data;
            pio_pkg::OP_SET:    nval = src | req.data;
            pio_pkg::OP_CLEAR:  nval = src & ~req.data;
            pio_pkg::OP_TOGGLE: nval = src ^ req.data;
            default:            nval = src;
        endcase
    end

    // per-port write strobes; port 5 has none
    always_comb begin
        data_we = 6'h00;
        dir_we  = 6'h00;
        od_we   = 6'h00;
        if (wr && req.port < `PIO_PORT5) begin
            if (req.target == pio_pkg::TGT_DATA) begin
                data_we[req.port] = 1'b1;
            end
            if (req.target == pio_pkg::TGT_DIR) begin
                dir_we[req.port] = 1'b1;
            end
            if (req.target == pio_pkg::TGT_OD) begin
                od_we[req.port] = 1'b1;
            end
        end
    end

    // extension register set for the shared port 1 pins
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            xdata_reg <= `PIO_DATA_RST;
            xdir_reg  <= `PIO_DIR_RST;
            xod_reg   <= `PIO_OD_RST;
        end else if (wr) begin
            if (req.target == pio_pkg::TGT_XDATA) begin
                xdata_reg <= (xdata_reg & ~req.mask) | (nval & req.mask);
            end
            if (req.target == pio_pkg::TGT_XDIR) begin
                xdir_reg <= (xdir_reg & ~req.mask) | (nval & req.mask);
            end
            if (req.target == pio_pkg::TGT_XOD) begin
                xod_reg <= (xod_reg & ~req.mask) | (nval & req.mask);
            end
        end
    end

    // enabled extensions take their pins; otherwise alternate functions or standard bits rule
    assign xmask = (I_XPER_EN[`PIO_XEN_PWM] ? `PIO_PULSE_PINS : 16'h0000)
                 | (I_XPER_EN[`PIO_XEN_ASC] ? `PIO_ASYNC_PINS : 16'h0000)
                 | (I_XPER_EN[`PIO_XEN_SSC] ? `PIO_SYNC_PINS : 16'h0000);
    // extension set outranks ordinary alternate functions on port 1
    assign p1_ovr.en  = xmask | I_ALT_EN[`PIO_P1_LO +: `PIO_P1_W];
    assign p1_ovr.out = (xmask & xdata_reg)
                      | (~xmask & I_ALT_OUT[`PIO_P1_LO +: `PIO_P1_W]);
    assign p1_ovr.dir = (xmask & xdir_reg)
                      | (~xmask & I_ALT_DIR[`PIO_P1_LO +: `PIO_P1_W]);
    assign p1_ovr.od  = xmask & xod_reg;

    // port 0: 16 lines, push/pull only
    pio_port #(
        .W     (`PIO_P0_W),
        .OD_EN (1'b0)
    ) u_port0 (
        .i_clk      (I_CLK),
        .i_rst_b    (I_RST_B),
        .i_st_en    (st_en_reg),
        .i_pin      (pin_sync[`PIO_P0_LO +: `PIO_P0_W]),
        .i_data_we  (data_we[0]),
        .i_dir_we   (dir_we[0]),
        .i_od_we    (od_we[0]),
        .i_wval     (nval),
        .i_wmask    (req.mask),
        .i_ovr_en   (I_ALT_EN[`PIO_P0_LO +: `PIO_P0_W]),
        .i_ovr_out  (I_ALT_OUT[`PIO_P0_LO +: `PIO_P0_W]),
        .i_ovr_dir  (I_ALT_DIR[`PIO_P0_LO +: `PIO_P0_W]),
        .i_ovr_od   (16'h0000),
        .o_rd       (rd0),
        .o_pin_out  (O_PIN_OUT[`PIO_P0_LO +: `PIO_P0_W]),
        .o_pin_oe_b (O_PIN_OE_B[`PIO_P0_LO +: `PIO_P0_W])
    );

    // port 1: open drain only through the extension set
    pio_port #(
        .W     (`PIO_P1_W),
        .OD_EN (1'b0)
    ) u_port1 (
        .i_clk      (I_CLK),
        .i_rst_b    (I_RST_B),
        .i_st_en    (st_en_reg),
        .i_pin      (pin_sync[`PIO_P1_LO +: `PIO_P1_W]),
        .i_data_we  (data_we[1]),
        .i_dir_we   (dir_we[1]),
        .i_od_we    (od_we[1]),
        .i_wval     (nval),
        .i_wmask    (req.mask),
        .i_ovr_en   (p1_ovr.en),
        .i_ovr_out  (p1_ovr.out),
        .i_ovr_dir  (p1_ovr.dir),
        .i_ovr_od   (p1_ovr.od),
        .o_rd       (rd1),
        .o_pin_out  (O_PIN_OUT[`PIO_P1_LO +: `PIO_P1_W]),
        .o_pin_oe_b (O_PIN_OE_B[`PIO_P1_LO +: `PIO_P1_W])
    );

    // port 2: 14 lines with open drain
    pio_port #(
        .W     (`PIO_P2_W),
        .OD_EN (1'b1)
    ) u_port2 (
        .i_clk      (I_CLK),
        .i_rst_b    (I_RST_B),
        .i_st_en    (st_en_reg),
        .i_pin      (pin_sync[`PIO_P2_LO +: `PIO_P2_W]),
        .i_data_we  (data_we[2]),
        .i_dir_we   (dir_we[2]),
        .i_od_we    (od_we[2]),
        .i_wval     (nval[`PIO_P2_W-1:0]),
        .i_wmask    (req.mask[`PIO_P2_W-1:0]),
        .i_ovr_en   (I_ALT_EN[`PIO_P2_LO +: `PIO_P2_W]),
        .i_ovr_out  (I_ALT_OUT[`PIO_P2_LO +: `PIO_P2_W]),
        .i_ovr_dir  (I_ALT_DIR[`PIO_P2_LO +: `PIO_P2_W]),
        .i_ovr_od   (14'h0000),
        .o_rd       (rd2),
        .o_pin_out  (O_PIN_OUT[`PIO_P2_LO +: `PIO_P2_W]),
        .o_pin_oe_b (O_PIN_OE_B[`PIO_P2_LO +: `PIO_P2_W])
    );

    // port 3: 12 lines with open drain
    pio_port #(
        .W     (`PIO_P3_W),
        .OD_EN (1'b1)
    ) u_port3 (
        .i_clk      (I_CLK),
        .i_rst_b    (I_RST_B),
        .i_st_en    (st_en_reg),
        .i_pin      (pin_sync[`PIO_P3_LO +: `PIO_P3_W]),
        .i_data_we  (data_we[3]),
        .i_dir_we   (dir_we[3]),
        .i_od_we    (od_we[3]),
        .i_wval     (nval[`PIO_P3_W-1:0]),
        .i_wmask    (req.mask[`PIO_P3_W-1:0]),
        .i_ovr_en   (I_ALT_EN[`PIO_P3_LO +: `PIO_P3_W]),
        .i_ovr_out  (I_ALT_OUT[`PIO_P3_LO +: `PIO_P3_W]),
        .i_ovr_dir  (I_ALT_DIR[`PIO_P3_LO +: `PIO_P3_W]),
        .i_ovr_od   (12'h000),
        .o_rd       (rd3),
        .o_pin_out  (O_PIN_OUT[`PIO_P3_LO +: `PIO_P3_W]),
        .o_pin_oe_b (O_PIN_OE_B[`PIO_P3_LO +: `PIO_P3_W])
    );

    // port 4: 8 lines with open drain
    pio_port #(
        .W     (`PIO_P4_W),
        .OD_EN (1'b1)
    ) u_port4 (
        .i_clk      (I_CLK),
        .i_rst_b    (I_RST_B),
        .i_st_en    (st_en_reg),
        .i_pin      (pin_sync[`PIO_P4_LO +: `PIO_P4_W]),
        .i_data_we  (data_we[4]),
        .i_dir_we   (dir_we[4]),
        .i_od_we    (od_we[4]),
        .i_wval     (nval[`PIO_P4_W-1:0]),
        .i_wmask    (req.mask[`PIO_P4_W-1:0]),
        .i_ovr_en   (I_ALT_EN[`PIO_P4_LO +: `PIO_P4_W]),
        .i_ovr_out  (I_ALT_OUT[`PIO_P4_LO +: `PIO_P4_W]),
        .i_ovr_dir  (I_ALT_DIR[`PIO_P4_LO +: `PIO_P4_W]),
        .i_ovr_od   (8'h00),
        .o_rd       (rd4),
        .o_pin_out  (O_PIN_OUT[`PIO_P4_LO +: `PIO_P4_W]),
        .o_pin_oe_b (O_PIN_OE_B[`PIO_P4_LO +: `PIO_P4_W])
    );

    // read answer registered one cycle after the request
    always_ff @(posedge I_CLK) begin
        if (!I_RST_B) begin
            O_RD_DATA  <= 16'h0000;
            O_RD_VALID <= 1'b0;
        end else begin
            O_RD_VALID <= req.valid && (req.op == pio_pkg::OP_READ);
            if (req.valid && req.op == pio_pkg::OP_READ) begin
                O_RD_DATA <= src;
            end
        end
    end
endmodule

// >>> pio_bank_monitor.sv
// concurrent checks on the port bank top-level ports
`timescale 1ns/1ps
module pio_bank_monitor (
    input wire logic        I_CLK,
    input wire logic        I_RST_B,
    input wire logic        I_REQ_VALID,
    input wire logic [2:0]  I_REQ_TARGET,
    input wire logic [2:0]  I_REQ_PORT,
    input wire logic [2:0]  I_REQ_OP,
    input wire logic [15:0] I_REQ_MASK,
    input wire logic [15:0] I_REQ_DATA,
    input wire logic [2:0]  I_XPER_EN,
    input wire logic [75:0] I_PIN_IN,
    input wire logic [65:0] I_ALT_EN,
    input wire logic [65:0] I_ALT_OUT,
    input wire logic [65:0] I_ALT_DIR,
    input wire logic [65:0] O_PIN_OUT,
    input wire logic [65:0] O_PIN_OE_B,
    input wire logic [15:0] O_RD_DATA,
    input wire logic        O_RD_VALID
);
    default clocking cb @(posedge I_CLK); endclocking
    // a read request and a cycle with no request, read or write
    logic rd_req;
    logic quiet;
    assign rd_req = I_REQ_VALID && I_REQ_OP == 3'h0;
    assign quiet  = !I_REQ_VALID;

    a_rd_pulse: assert property (disable iff (!I_RST_B) rd_req |=> O_RD_VALID)
        else $error("read answer missing");
    a_rd_quiet: assert property (disable iff (!I_RST_B) !rd_req |=> !O_RD_VALID)
        else $error("read answer without request");
    a_rd_hold: assert property (disable iff (!I_RST_B) !rd_req |=> $stable(O_RD_DATA))
        else $error("read data moved without read");
    a_p5_width: assert property (disable iff (!I_RST_B)
        rd_req && I_REQ_PORT == 3'h5 |=> O_RD_DATA[15:10] == 6'h00)
        else $error("input port read wider than ten bits");
    a_p2_width: assert property (disable iff (!I_RST_B)
        rd_req && I_REQ_PORT == 3'h2 |=> O_RD_DATA[15:14] == 2'h0)
        else $error("port two read wider than fourteen bits");
    // no disable here: the reset itself is the cause
    a_reset_float: assert property (!I_RST_B |=> &O_PIN_OE_B && !O_RD_VALID)
        else $error("driver on or answer during reset");
    a_dir_float: assert property (disable iff (!I_RST_B)
        I_REQ_VALID && I_REQ_TARGET == 3'h1 && I_REQ_PORT == 3'h2 && I_REQ_OP == 3'h1
        && I_REQ_MASK[0] && !I_REQ_DATA[0] && !I_ALT_EN[32] ##1 !I_ALT_EN[32]
        |=> O_PIN_OE_B[32])
        else $error("input line still driven");
    a_alt_take: assert property (disable iff (!I_RST_B)
        (I_ALT_EN[0] && I_ALT_DIR[0])[*2] ##0 $stable(I_ALT_OUT[0])
        |=> !O_PIN_OE_B[0] && O_PIN_OUT[0] == $past(I_ALT_OUT[0]))
        else $error("peripheral takeover not on pin");
    a_oe_quiet: assert property (disable iff (!I_RST_B)
        (quiet && $stable(I_XPER_EN) && $stable(I_ALT_EN) && $stable(I_ALT_DIR))[*2]
        |=> $stable(O_PIN_OE_B))
        else $error("drivers changed with no cause");

    c_read: cover property (disable iff (!I_RST_B) rd_req ##1 O_RD_VALID);
    c_ext: cover property (disable iff (!I_RST_B) I_XPER_EN != 3'h0 && I_REQ_VALID);
    c_alt: cover property (disable iff (!I_RST_B) I_ALT_EN[0] && !O_PIN_OE_B[0]);
endmodule

bind pio_bank pio_bank_monitor u_mon (.*);

// >>> pio_ext_circuit.sv
// outside circuitry seen by the port pins
`timescale 1ns/1ps
module pio_ext_circuit (
    input  wire logic [65:0] i_pin_out,
    input  wire logic [65:0] i_pin_oe_b,
    input  wire logic [75:0] i_ext_val,
    output logic      [75:0] o_pin
);
    // a released line shows the outside level, never the last driven one
    always_comb begin
        for (int i = 0; i < 66; i++) begin
            o_pin[i] = i_pin_oe_b[i] ? i_ext_val[i] : i_pin_out[i];
        end
        o_pin[75:66] = i_ext_val[75:66];
    end
endmodule

// >>> tb.sv
// self-checking bench for the port bank
`timescale 1ns/1ps
`include "pio_defines.svh"
module tb;
    logic        clk;
    logic        rst_b;
    logic        req_valid;
    logic [2:0]  req_tgt;
    logic [2:0]  req_port;
    logic [2:0]  req_op;
    logic [15:0] req_mask;
    logic [15:0] req_data;
    logic [2:0]  xper_en;
    logic [75:0] pin;
    logic [75:0] ext_val;
    logic [65:0] alt_en;
    logic [65:0] alt_out;
    logic [65:0] alt_dir;
    logic [65:0] pin_out;
    logic [65:0] pin_oe_b;
    logic [15:0] rd_data;
    logic        rd_valid;
    logic [15:0] got_data;
    logic        got_valid;
    logic [95:0] r;
    logic [31:0] lfsr;
    logic [15:0] m;
    logic [15:0] lat [5];
    logic [15:0] dr  [5];
    logic [15:0] od  [5];
    int          lo  [6] = '{`PIO_P0_LO, `PIO_P1_LO, `PIO_P2_LO, `PIO_P3_LO, `PIO_P4_LO, `PIO_P5_LO};
    int          wd  [6] = '{`PIO_P0_W, `PIO_P1_W, `PIO_P2_W, `PIO_P3_W, `PIO_P4_W, `PIO_P5_W};
    int          errors;
    int          checks_done;
    int          cycles = 0;

    pio_bank dut (
        .I_CLK(clk), .I_RST_B(rst_b), .I_REQ_VALID(req_valid), .I_REQ_TARGET(req_tgt),
        .I_REQ_PORT(req_port), .I_REQ_OP(req_op), .I_REQ_MASK(req_mask),
        .I_REQ_DATA(req_data), .I_XPER_EN(xper_en), .I_PIN_IN(pin), .I_ALT_EN(alt_en),
        .I_ALT_OUT(alt_out), .I_ALT_DIR(alt_dir), .O_PIN_OUT(pin_out),
        .O_PIN_OE_B(pin_oe_b), .O_RD_DATA(rd_data), .O_RD_VALID(rd_valid)
    );
    pio_ext_circuit u_ext (
        .i_pin_out(pin_out), .i_pin_oe_b(pin_oe_b), .i_ext_val(ext_val), .o_pin(pin)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // hang guard, far above the few thousand cycles the run needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end

    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    // model read: output lines give the latch, input lines the outside level
    function automatic logic [15:0] exp_rd(int t, int p);
        logic [15:0] v;
        v = 16'h0000;
        if (t == 0 && p == 5) begin
            v[9:0] = ext_val[75:66];
        end else if (t == 0) begin
            for (int b = 0; b < wd[p]; b++) begin
                v[b] = dr[p][b] ? lat[p][b] : ext_val[lo[p] + b];
            end
        end
        return v;
    endfunction

    task automatic chk(string name, logic [75:0] seen, logic [75:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // one request; model follows; refused writes leave the model alone
    task automatic req(int t, int p, int op, logic [15:0] mk, logic [15:0] d);
        logic [15:0] s;
        logic [15:0] n;
        if (op != 0 && p < 5 && t < 3 && !(t == 2 && p < 2)) begin
            // direction and open drain read back as 0, so that is their source
            s = (t == 0) ? exp_rd(0, p) : 16'h0000;
            case (op)
                1: n = d;
                2: n = s | d;
                3: n = s & ~d;
                default: n = s ^ d;
            endcase
            // unmasked bits keep the register, never the pin
            if (t == 0) lat[p] = (lat[p] & ~mk) | (n & mk);
            else if (t == 1) dr[p] = (dr[p] & ~mk) | (n & mk);
            else od[p] = (od[p] & ~mk) | (n & mk);
        end
        req_tgt = t[2:0];
        req_port = p[2:0];
        req_op = op[2:0];
        req_mask = mk;
        req_data = d;
        req_valid = 1'b1;
        @(negedge clk);
        got_valid = rd_valid;
        got_data = rd_data;
        req_valid = 1'b0;
        @(negedge clk);
    endtask

    task automatic rd(int t, int p);
        logic [15:0] e;
        e = exp_rd(t, p);
        req(t, p, 0, 16'h0000, 16'h0000);
        chk("rd_valid", got_valid, 1'b1);
        chk("rd_data", got_data, e);
    endtask

    task automatic chk_pins();
        logic [65:0] eo;
        logic [65:0] eb;
        for (int p = 0; p < 5; p++)
            for (int b = 0; b < wd[p]; b++) begin
                eb[lo[p] + b] = !(dr[p][b] && !(od[p][b] && lat[p][b]));
                eo[lo[p] + b] = lat[p][b];
            end
        chk("pin_oe_b", pin_oe_b, eb);
        chk("pin_out", pin_out & ~eb, eo & ~eb);
    endtask

    initial begin
        {rst_b, req_valid, req_tgt, req_port, req_op, req_mask, req_data} = '0;
        {xper_en, alt_en, alt_out, alt_dir} = '0;
        ext_val = 76'h0;
        lfsr = 32'h00015398;
        errors = 0;
        checks_done = 0;
        for (int p = 0; p < 5; p++) begin
            {lat[p], dr[p], od[p]} = '0;
        end
        repeat (20) @(negedge clk);
        chk("oe_b_reset", pin_oe_b, {66{1'b1}});
        rst_b = 1'b1;
        repeat (6) @(negedge clk);
        chk_pins();
        // random traffic; waits cover sync flops plus one state time
        for (int i = 0; i < 300; i++) begin
            r = {rnd(), rnd(), rnd()};
            ext_val = r[75:0];
            repeat (6) @(negedge clk);
            r[31:0] = rnd();
            req(r[1:0] % 3, r[4:2] % 6, 1 + r[7:5] % 4, r[31:16], rnd());
            chk_pins();
            repeat (6) @(negedge clk);
            r[31:0] = rnd();
            rd(r[1:0] % 3, r[4:2] % 6);
        end
        // line 32 driven low, then turned back to input
        req(1, 2, 1, 16'h0001, 16'h0001);
        req(0, 2, 1, 16'h0001, 16'h0000);
        chk_pins();
        req(1, 2, 1, 16'h0001, 16'h0000);
        chk_pins();
        // extension peripherals own their port 1 pins; standard bits ignored
        for (int k = 0; k < 3; k++) begin
            m = (k == 0) ? `PIO_PULSE_PINS : (k == 1) ? `PIO_ASYNC_PINS : `PIO_SYNC_PINS;
            xper_en = 3'h1 << k;
            req(3, 1, 1, m, m);
            req(4, 1, 1, m, m);
            req(1, 1, 1, m, 16'h0000);
            chk("ext_out", pin_out[31:16] & m, m);
            chk("ext_oe_b", pin_oe_b[31:16] & m, 16'h0000);
            req(5, 1, 2, m, m);
            chk("ext_od", pin_oe_b[31:16] & m, m);
            xper_en = 3'h0;
            repeat (3) @(negedge clk);
            chk_pins();
        end
        // peripheral takeover of line 0
        alt_en[0] = 1'b1;
        alt_dir[0] = 1'b1;
        alt_out[0] = ~lat[0][0];
        repeat (3) @(negedge clk);
        chk("alt_out", pin_out[0], !lat[0][0]);
        chk("alt_oe_b", pin_oe_b[0], 1'b0);
        alt_en[0] = 1'b0;
        repeat (3) @(negedge clk);
        chk_pins();
        stop_test();
    end
endmodule
